// ---- rtl/vref_lvd_regs.svh ----
// Purpose: register offsets, field positions, reset values and masks
// Assumes: byte addresses on a 32-bit Avalon-MM word bus
// Notes: definitions only
`ifndef VREF_LVD_REGS_SVH
`define VREF_LVD_REGS_SVH

// ==========================================================
// Register word indices and offsets (byte addresses)
`define REF_CTRL_INDEX 8'h9b
`define SUPPLY_MON_INDEX 8'h9c
`define IRQ_CTRL_INDEX 8'ha0
`define REF_CTRL_ADDR 10'h26c
`define SUPPLY_MON_ADDR 10'h270
`define IRQ_CTRL_ADDR 10'h280

// ==========================================================
// Field positions
`define HIGH_REF_EN_BIT 7
`define LOW_REF_EN_BIT 6
`define HIGH_REF_OE_BIT 5
`define LOW_REF_OE_BIT 4
`define BANDGAP_STABLE_BIT 5
`define MONITOR_EN_BIT 4
`define IRQ_FLAG_BIT 0
`define IRQ_ENABLE_BIT 1

// ==========================================================
// Reset values, masks and trip codes
`define REF_CTRL_RESET 8'h00
`define TRIP_SELECT_RESET 4'h5
`define REF_CTRL_WMASK 8'hf0
`define TRIP_EXTERNAL 4'hf
`define TRIP_LOWEST_VALID 4'h4

`endif

// ---- rtl/vref_lvd_pkg.sv ----
// Purpose: shared types of the reference and supply monitor block
// Assumes: used together with vref_lvd_regs.svh
// Notes: types only
package vref_lvd_pkg;

  // Analog-side request group
  typedef struct packed {
    logic bandgap_on;
    logic generator_on;
    logic high_amp_on;
    logic low_amp_on;
    logic high_pin_drive;
    logic low_pin_drive;
    logic monitor_on;
    logic external_select;
  } analog_ctrl_type;

  // Synchronised analog status group
  typedef struct packed {
    logic supply_low;
    logic bandgap_settled;
  } analog_stat_type;

  // Trip code classes
  typedef enum logic [1:0] {
    TRIP_RESERVED = 2'b00,
    TRIP_INTERNAL = 2'b01,
    TRIP_EXT = 2'b10
  } trip_class_type;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;

endpackage

// ---- rtl/sync2.sv ----
// Purpose: two flip-flop synchroniser for a vector of levels
// Assumes: inputs are slow levels from the analog domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_reg;

  // Zero width has nothing to carry
  if (WIDTH < 1) begin : g_width_check
    $error("sync2 needs a WIDTH of at least 1");
  end

  // ==========================================================
  // Two-stage capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end

endmodule

// ---- rtl/trip_decode.sv ----
// Purpose: classify the trip select code
// Assumes: 4-bit code
// Notes: purely combinational
`timescale 1ns/1ps
`include "vref_lvd_regs.svh"
module trip_decode (
  // Code in
  input wire logic [3:0] trip_select,
  // Class out
  output vref_lvd_pkg::trip_class_type trip_class
);
  import vref_lvd_pkg::*;

  // ==========================================================
  // External, internal level or reserved
  always_comb begin
    if (trip_select == `TRIP_EXTERNAL) begin
      trip_class = TRIP_EXT;
    end else if (trip_select >= `TRIP_LOWEST_VALID) begin
      trip_class = TRIP_INTERNAL;
    end else begin
      trip_class = TRIP_RESERVED;
    end
  end

endmodule

// ---- rtl/vref_lvd_ctrl.sv ----
// Purpose: control of bandgap, two references and the supply monitor
// Assumes: Avalon-MM slave with waitrequest, 25 MHz clk, analog parts outside
// Notes: comparator and settle inputs are synchronised here
//
// Overview of operation
// - High enable powers high amp and generator
// - Low enable powers low amp and generator
// - Generator stays on while any user needs
// - Bandgap on when any user enabled
// - Pin drive needs output enable and enable
// - Monitor enable bit activates the detector
// - Low supply sets flag; enable gates irq
// - Enabled supply interrupt wakes from sleep
// - Trip select is four bits, sixteen codes
// - Flag clear ignored while supply still low
// - Flag set blocked until bandgap settles
// - Read-only stable bit shows settled bandgap
// - Code 1111 selects external trip input
// - Decode external, internal levels, reserved
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "vref_lvd_regs.svh"
module vref_lvd_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // System inputs
  input wire logic brownout_enable,
  input wire logic sleeping,
  // Analog status, asynchronous
  input vref_lvd_pkg::analog_stat_type analog_stat,
  // Analog controls
  output vref_lvd_pkg::analog_ctrl_type analog_ctrl,
  // Interrupt and wake
  output logic supply_irq,
  output logic wake_request
);
  import vref_lvd_pkg::*;

  // ==========================================================
  // Declarations
  logic high_ref_enable;
  logic low_ref_enable;
  logic high_ref_pin_out_enable;
  logic low_ref_pin_out_enable;
  logic supply_monitor_enable;
  logic [3:0] trip_select;
  logic supply_low_flag;
  logic supply_low_irq_enable;
  logic bandgap_stable;
  logic bandgap_on;
  logic generator_on;
  logic flag_clear;
  logic wr_hit;
  logic rd_hit;
  analog_stat_type stat_sync;
  trip_class_type trip_class;
  bus_state_type bus_state_reg;
  bus_state_type bus_state_next;
  logic [31:0] read_value;
  logic mapped;
  logic ref_wr;
  logic mon_wr;
  logic irq_wr;
  logic flag_set;
  logic flag_clear_ok;
  logic irq_active;
  logic [7:0] ref_image;
  logic [7:0] mon_image;

  // Register byte writable only when its own lane is enabled; reads ignore byteenable
  function automatic logic lane_hit(input logic [3:0] be, input logic [9:0] addr);
    lane_hit = be[addr[1:0]];
  endfunction

  // Write strobe of one register: answer cycle, its address, its lane enabled
  function automatic logic write_hit(input logic hit, input logic [9:0] addr,
                                     input logic [9:0] target, input logic [3:0] be);
    write_hit = hit && (addr == target) && lane_hit(be, addr);
  endfunction

  // ==========================================================
  // Analog inputs cross into the core clock
  sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(analog_stat),
    .sync_out(stat_sync)
  );

  trip_decode u_trip (
    .trip_select(trip_select),
    .trip_class(trip_class)
  );

  // ==========================================================
  // Data always sits in bits 7:0, so each register needs a word of its own
  if (((`REF_CTRL_ADDR % 4) != 0) || ((`SUPPLY_MON_ADDR % 4) != 0) ||
      ((`IRQ_CTRL_ADDR % 4) != 0)) begin : g_align_check
    $error("register offsets must be word aligned");
  end

  // ==========================================================
  // Bus handshake: one wait cycle, answer on the second
  assign wr_hit = (bus_state_reg == BUS_ANSWER) && write;
  assign rd_hit = (bus_state_reg == BUS_ANSWER) && read;

  // Register images as software reads them; unused bits read zero
  assign ref_image = {high_ref_enable, low_ref_enable,
                      high_ref_pin_out_enable, low_ref_pin_out_enable, 4'h0};
  assign mon_image = {2'b00, bandgap_stable, supply_monitor_enable, trip_select};

  // Address decode
  always_comb begin
    mapped = 1'b1;
    read_value = 32'h0000_0000;
    case (address)
      `REF_CTRL_ADDR: begin
        read_value[7:0] = ref_image;
      end
      `SUPPLY_MON_ADDR: begin
        read_value[7:0] = mon_image;
      end
      `IRQ_CTRL_ADDR: begin
        read_value[`IRQ_FLAG_BIT] = supply_low_flag;
        read_value[`IRQ_ENABLE_BIT] = supply_low_irq_enable;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Bus state machine
  always_comb begin
    case (bus_state_reg)
      BUS_IDLE: bus_state_next = (read || write) ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: bus_state_next = BUS_DONE;
      BUS_DONE: bus_state_next = BUS_IDLE;
      default: bus_state_next = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // Waitrequest drops for exactly the answer cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
      response <= 2'b00;
    end else begin
      waitrequest <= !(bus_state_next == BUS_ANSWER);
      if (bus_state_next == BUS_ANSWER) begin
        readdata <= read ? read_value : 32'h0000_0000;
        response <= mapped ? 2'b00 : 2'b10;
      end
    end
  end

  // ==========================================================
  // Write strobes, one per register, in the answer cycle only
  assign ref_wr = write_hit(wr_hit, address, `REF_CTRL_ADDR, byteenable);
  assign mon_wr = write_hit(wr_hit, address, `SUPPLY_MON_ADDR, byteenable);
  assign irq_wr = write_hit(wr_hit, address, `IRQ_CTRL_ADDR, byteenable);

  // ==========================================================
  // Reference control register, upper nibble only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {high_ref_enable, low_ref_enable,
       high_ref_pin_out_enable, low_ref_pin_out_enable} <= 4'h0;
    end else if (ref_wr) begin
      high_ref_enable <= writedata[`HIGH_REF_EN_BIT];
      low_ref_enable <= writedata[`LOW_REF_EN_BIT];
      high_ref_pin_out_enable <= writedata[`HIGH_REF_OE_BIT];
      low_ref_pin_out_enable <= writedata[`LOW_REF_OE_BIT];
    end
  end

  // Supply monitor control; stable bit is read only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_monitor_enable <= 1'b0;
      trip_select <= `TRIP_SELECT_RESET;
    end else if (mon_wr) begin
      supply_monitor_enable <= writedata[`MONITOR_EN_BIT];
      trip_select <= writedata[3:0];
    end
  end

  // Interrupt enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_low_irq_enable <= 1'b0;
    end else if (irq_wr) begin
      supply_low_irq_enable <= writedata[`IRQ_ENABLE_BIT];
    end
  end

  // Write zero to the flag bit requests a clear
  assign flag_clear = irq_wr && !writedata[`IRQ_FLAG_BIT];

  // ==========================================================
  // Power gating of bandgap and generator
  assign bandgap_on = brownout_enable || supply_monitor_enable ||
                      high_ref_enable || low_ref_enable;
  assign generator_on = bandgap_on;

  // Stable bit follows the settled level only while powered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bandgap_stable <= 1'b0;
    end else begin
      bandgap_stable <= bandgap_on && stat_sync.bandgap_settled;
    end
  end

  // ==========================================================
  // Trip only counts once the monitor is on and the bandgap has settled
  assign flag_set = supply_monitor_enable && bandgap_stable && stat_sync.supply_low;

  // Clear honoured only once the supply is back above the trip point
  assign flag_clear_ok = flag_clear && !stat_sync.supply_low;

  // Supply low flag: set wins over clear, clear refused while low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_low_flag <= 1'b0;
    end else if (flag_set) begin
      supply_low_flag <= 1'b1;
    end else if (flag_clear_ok) begin
      supply_low_flag <= 1'b0;
    end
  end

  // Pending interrupt, shared by irq and wake
  assign irq_active = supply_low_flag && supply_low_irq_enable;

  // Interrupt and wake outputs, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      supply_irq <= irq_active;
      wake_request <= sleeping && irq_active;
    end
  end

  // ==========================================================
  // Analog control outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.bandgap_on <= bandgap_on;
      analog_ctrl.generator_on <= generator_on;
      analog_ctrl.high_amp_on <= high_ref_enable;
      analog_ctrl.low_amp_on <= low_ref_enable;
      analog_ctrl.high_pin_drive <= high_ref_pin_out_enable && high_ref_enable;
      analog_ctrl.low_pin_drive <= low_ref_pin_out_enable && low_ref_enable;
      analog_ctrl.monitor_on <= supply_monitor_enable;
      analog_ctrl.external_select <= (trip_class == TRIP_EXT);
    end
  end

endmodule

// ---- dv/vref_lvd_ctrl_properties.sv ----
// Purpose: port checks of the reference and supply monitor control
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module vref_lvd_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // System and analog
  input wire logic brownout_enable,
  input wire logic sleeping,
  input vref_lvd_pkg::analog_ctrl_type analog_ctrl,
  input wire logic supply_irq,
  input wire logic wake_request
);
  import vref_lvd_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // =====================================
  // Bus answer: one low cycle, then idle
  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence
  AST_ANSWER: assert property ($rose(read || write) |-> ##[1:3] answer_s)
    else $error("request not answered in time");
  // =====================================
  // Power gating relations
  AST_GEN_BG: assert property (analog_ctrl.generator_on == analog_ctrl.bandgap_on)
    else $error("generator and bandgap differ");
  AST_GEN_USERS: assert property ($past(rst_n) |-> analog_ctrl.generator_on ==
    ($past(brownout_enable) || analog_ctrl.monitor_on || analog_ctrl.high_amp_on ||
     analog_ctrl.low_amp_on))
    else $error("generator state does not match its users");
  AST_HIGH_AMP: assert property (analog_ctrl.high_amp_on |-> analog_ctrl.bandgap_on)
    else $error("high amp without bandgap");
  AST_LOW_AMP: assert property (analog_ctrl.low_amp_on |-> analog_ctrl.bandgap_on)
    else $error("low amp without bandgap");
  AST_HIGH_PIN: assert property (analog_ctrl.high_pin_drive |-> analog_ctrl.high_amp_on)
    else $error("high pin driven while disabled");
  AST_LOW_PIN: assert property (analog_ctrl.low_pin_drive |-> analog_ctrl.low_amp_on)
    else $error("low pin driven while disabled");
  AST_BROWNOUT: assert property (brownout_enable |=> analog_ctrl.bandgap_on)
    else $error("brown-out left bandgap off");
  AST_MON_BG: assert property (analog_ctrl.monitor_on |-> analog_ctrl.bandgap_on)
    else $error("monitor without bandgap");
  // Flag needs a running bandgap; wake only while asleep
  AST_IRQ_BG: assert property ($rose(supply_irq) |-> $past(analog_ctrl.bandgap_on))
    else $error("irq before bandgap");
  AST_WAKE: assert property (wake_request |-> supply_irq && $past(sleeping))
    else $error("wake without irq or sleep");
endmodule
bind vref_lvd_ctrl vref_lvd_ctrl_props vref_lvd_ctrl_props_i (.clk(clk), .rst_n(rst_n),
  .read(read), .write(write), .waitrequest(waitrequest), .brownout_enable(brownout_enable),
  .sleeping(sleeping), .analog_ctrl(analog_ctrl), .supply_irq(supply_irq),
  .wake_request(wake_request));

// ---- dv/test_vref_lvd_ctrl.sv ----
// Purpose: self-checking bench of the reference and monitor control
// Assumes: Avalon master per the hand-over timing
// Notes: analog status held as slow levels
`timescale 1ns/1ps
`include "vref_lvd_regs.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module test_vref_lvd_ctrl;
  import vref_lvd_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic read = 0;
  logic write = 0;
  logic brownout_enable = 0;
  logic sleeping = 0;
  logic [9:0] address = '0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = '0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  analog_stat_type analog_stat = '0;
  analog_ctrl_type analog_ctrl;
  logic supply_irq;
  logic wake_request;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [1:0] r;
  logic [7:0] rc;
  logic [7:0] mc;
  logic bo;

  always #20 clk = ~clk;

  vref_lvd_ctrl vref_lvd_ctrl_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .brownout_enable(brownout_enable),
    .sleeping(sleeping), .analog_stat(analog_stat), .analog_ctrl(analog_ctrl),
    .supply_irq(supply_irq), .wake_request(wake_request));

  // =====================================
  // Verdict and hang guard
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // Held until waitrequest samples low; never assumes a latency
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    byteenable <= 4'hf;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Expected analog controls from register images
  function analog_ctrl_type exp_ctrl(logic [7:0] c, logic [7:0] m, logic b);
    logic on;
    on = c[7] | c[6] | m[4] | b;
    return {on, on, c[7], c[6], c[7] & c[5], c[6] & c[4], m[4], m[3:0] == 4'hf};
  endfunction

  // =====================================
  // Main sequence
  initial begin
    void'($urandom(32'h1a99cf63));
    wt(2);
    rst_n <= 1'b1;
    bus(0, `REF_CTRL_ADDR, 0);
    `CHK("ref reset", 32'h0, q)
    bus(0, `SUPPLY_MON_ADDR, 0);
    `CHK("mon reset", 32'h5, q)
    `CHK("ok resp", 2'b00, r)
    bus(1, 10'h3fc, 8'hff);
    `CHK("unmapped resp", 2'b10, r)
    `CHK("ctrl reset", 8'h00, analog_ctrl)
    $display("test reset done");
    // Every trip code, random enables and brown-out
    for (int i = 0; i < 16; i++) begin
      rc = 8'($urandom);
      mc = {3'b0, 1'($urandom), i[3:0]};
      bo = 1'($urandom);
      brownout_enable <= bo;
      bus(1, `REF_CTRL_ADDR, rc);
      bus(1, `SUPPLY_MON_ADDR, mc);
      wt(3);
      `CHK("ctrl", exp_ctrl(rc, mc, bo), analog_ctrl)
      bus(0, `REF_CTRL_ADDR, 0);
      `CHK("ref rd", {24'h0, rc & 8'hf0}, q)
      bus(0, `SUPPLY_MON_ADDR, 0);
      `CHK("mon rd", {27'h0, mc[4:0]}, q)
    end
    $display("test decode done");
    // Flag gated by stable bandgap, clear refused while low
    brownout_enable <= 1'b0;
    analog_stat.supply_low <= 1'b1;
    bus(1, `REF_CTRL_ADDR, 0);
    bus(1, `SUPPLY_MON_ADDR, 8'h05);
    bus(1, `SUPPLY_MON_ADDR, 8'h15);
    wt(8);
    bus(0, `IRQ_CTRL_ADDR, 0);
    `CHK("flag blocked", 32'h0, q)
    analog_stat.bandgap_settled <= 1'b1;
    do
      bus(0, `SUPPLY_MON_ADDR, 0);
    while (q[5] !== 1'b1);
    `CHK("stable", 32'h35, q)
    bus(0, `IRQ_CTRL_ADDR, 0);
    `CHK("flag set", 32'h1, q)
    `CHK("irq masked", 1'b0, supply_irq)
    bus(1, `IRQ_CTRL_ADDR, 8'h02);
    sleeping <= 1'b1;
    wt(3);
    `CHK("irq kept", 1'b1, supply_irq)
    `CHK("wake", 1'b1, wake_request)
    bus(1, `IRQ_CTRL_ADDR, 8'h00);
    bus(0, `IRQ_CTRL_ADDR, 0);
    `CHK("flag held", 32'h1, q)
    `CHK("wake off", 1'b0, wake_request)
    analog_stat.supply_low <= 1'b0;
    wt(4);
    bus(1, `IRQ_CTRL_ADDR, 8'h02);
    wt(3);
    `CHK("irq clr", 1'b0, supply_irq)
    bus(0, `IRQ_CTRL_ADDR, 0);
    `CHK("flag clr", 32'h2, q)
    bus(1, `SUPPLY_MON_ADDR, 8'h05);
    wt(3);
    bus(0, `SUPPLY_MON_ADDR, 0);
    `CHK("stable off", 32'h5, q)
    $display("test flag done");
    summarize();
  end
endmodule
